/* core/diag_pkg.sv */
// Constants for the diagnostic and external page address register bank.
// Assumes a 16-bit internal register bus with byte addresses as printed.
package diag_pkg;

	localparam logic [15:0] page_one_map_addr      = 16'hc018;
	localparam logic [15:0] page_two_map_addr      = 16'hc01a;
	localparam logic [15:0] upper_pin_enable_addr  = 16'hc038;
	localparam logic [15:0] ext_timing_addr        = 16'hc03a;
	localparam logic [15:0] usb_line_test_addr     = 16'hc03c;
	localparam logic [15:0] memory_test_addr       = 16'hc03e;

	localparam logic [15:0] page_map_reset         = 16'h0000;
	localparam logic [15:0] memory_test_reset      = 16'h0000;
	localparam logic [15:0] usb_line_test_reset    = 16'h0000;
	localparam logic [15:0] ext_timing_reset       = 16'h0000;

	localparam logic [15:0] usb_line_test_mask     = 16'hf077;
	localparam logic [15:0] memory_test_mask       = 16'h0701;
	localparam logic [15:0] upper_pin_enable_mask  = 16'h0008;
	localparam logic [15:0] ext_timing_mask        = 16'h3fff;

	localparam int port_en_lsb   = 12;
	localparam int pulldown_bit  = 6;
	localparam int ls_pullup_bit = 5;
	localparam int fs_pullup_bit = 4;
	localparam int force_lsb     = 0;
	localparam int arb_sel_lsb   = 8;
	localparam int monitor_bit   = 0;
	localparam int upper_en_bit  = 3;

	localparam logic [15:0] page_one_win_lo = 16'h8000;
	localparam logic [15:0] page_one_win_hi = 16'h9fff;
	localparam logic [15:0] page_two_win_lo = 16'ha000;
	localparam logic [15:0] page_two_win_hi = 16'hbfff;

	localparam logic [3:0] upper_pins_idle = 4'hf;
	localparam logic [2:0] arb_slots_last  = 3'h7;

	typedef enum logic [3:0] {
		force_k    = 4'b0001,
		force_j    = 4'b0010,
		force_jk   = 4'b0100,
		force_se0  = 4'b1000
	} line_force_t;

	function automatic line_force_t decode_force(input logic [2:0] sel);
		line_force_t f;
		f = force_k;
		if (sel[2]) begin
			f = force_se0;
		end else if (sel[1]) begin
			f = force_jk;
		end else if (sel[0]) begin
			f = force_j;
		end
		return f;
	endfunction

endpackage

/* core/diag_if.sv */
// Carries decoded diagnostic controls from the register bank to helpers.
// Assumes one clock domain; the register bank drives every control except slot_avail, which the throttle drives.
`timescale 1ns/1ps
`default_nettype none
interface diag_if;
	logic [3:0] port_en;
	logic       pulldown_en;
	logic       ls_pullup_en;
	logic       fs_pullup_en;
	logic [2:0] force_sel;
	logic [2:0] arb_sel;
	logic       slot_avail;

	modport regs (output port_en, pulldown_en, ls_pullup_en, fs_pullup_en,
		force_sel, arb_sel, input slot_avail);
	modport usb  (input port_en, pulldown_en, ls_pullup_en, fs_pullup_en,
		force_sel);
	modport arb  (input arb_sel, output slot_avail);
endinterface
`default_nettype wire

/* core/arb_throttle.sv */
// Memory arbitration throttle: marks dead slots in every group of eight.
// Assumes requesters hold their request level until granted.
`timescale 1ns/1ps
`default_nettype none
module arb_throttle
	import diag_pkg::*;
(
	input  wire logic clk,       // System clock.
	input  wire logic sys_rst,   // Synchronous reset, active high.
	diag_if.arb       ctl,       // Throttle setting and slot state.
	input  wire logic mem_req,   // Memory access requested, level.
	output logic      mem_gnt_q  // Access granted, high the cycle after each request in an available slot.
);
	logic [2:0] slot_q;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			slot_q <= 3'h0;
		end else begin
			slot_q <= slot_q + 3'h1;
		end
	end

	// The first n slots of each group of eight are dead.
	assign ctl.slot_avail = (slot_q >= ctl.arb_sel);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			mem_gnt_q <= 1'b0;
		end else begin
			mem_gnt_q <= mem_req && ctl.slot_avail;
		end
	end

	chk_dead_no_grant: assert property (
		@(posedge clk) disable iff (sys_rst)
		!ctl.slot_avail |=> !mem_gnt_q)
		else $error("grant issued in a dead slot");

	chk_full_rate: assert property (
		@(posedge clk) disable iff (sys_rst)
		(ctl.arb_sel == 3'h0 && mem_req) |=> mem_gnt_q)
		else $error("zero throttle did not grant every cycle");

	chk_last_slot: assert property (
		@(posedge clk) disable iff (sys_rst)
		(slot_q == arb_slots_last && mem_req) |=> mem_gnt_q)
		else $error("last slot of group was not available");
endmodule
`default_nettype wire

/* core/usb_line_force.sv */
// Applies diagnostic line states and test resistors to four USB ports.
// Assumes the pad ring resolves the data lines from drive and enable.
`timescale 1ns/1ps
`default_nettype none
module usb_line_force
	import diag_pkg::*;
#(
	parameter int PORTS = 4
) (
	input  wire logic   clk,          // System clock.
	input  wire logic   sys_rst,      // Synchronous reset, active high.
	diag_if.usb         ctl,          // Diagnostic controls.
	output logic [PORTS-1:0] dp_q,    // D+ drive value.
	output logic [PORTS-1:0] dp_oe_n_q, // D+ enable, low drives.
	output logic [PORTS-1:0] dm_q,    // D- drive value.
	output logic [PORTS-1:0] dm_oe_n_q, // D- enable, low drives.
	output logic [PORTS-1:0] pd_q,    // Pull-downs on both lines.
	output logic [PORTS-1:0] ls_pu_q, // Low-speed pull-up on D-.
	output logic [PORTS-1:0] fs_pu_q  // Full-speed pull-up on D+.
);
	logic        jk_q;
	line_force_t mode;
	logic        dp_d;
	logic        dm_d;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			jk_q <= 1'b0;
		end else begin
			jk_q <= ~jk_q;
		end
	end

	always_comb begin
		mode = decode_force(ctl.force_sel);
		case (mode)
			force_se0: begin
				dp_d = 1'b0;
				dm_d = 1'b0;
			end
			force_jk: begin
				dp_d = ~jk_q;
				dm_d = jk_q;
			end
			force_j: begin
				dp_d = 1'b1;
				dm_d = 1'b0;
			end
			force_k: begin
				dp_d = 1'b0;
				dm_d = 1'b1;
			end
			default: begin
				dp_d = 1'b0;
				dm_d = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			dp_q      <= '0;
			dm_q      <= '0;
			dp_oe_n_q <= '1;
			dm_oe_n_q <= '1;
		end else begin
			dp_q      <= {PORTS{dp_d}} & ctl.port_en;
			dm_q      <= {PORTS{dm_d}} & ctl.port_en;
			dp_oe_n_q <= ~ctl.port_en;
			dm_oe_n_q <= ~ctl.port_en;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pd_q    <= '0;
			ls_pu_q <= '0;
			fs_pu_q <= '0;
		end else begin
			pd_q    <= {PORTS{ctl.pulldown_en}} & ctl.port_en;
			ls_pu_q <= {PORTS{ctl.ls_pullup_en}} & ctl.port_en;
			fs_pu_q <= {PORTS{ctl.fs_pullup_en}} & ctl.port_en;
		end
	end

	chk_se0_force: assert property (
		@(posedge clk) disable iff (sys_rst)
		(ctl.force_sel[2] && ctl.port_en[0]) |=> (!dp_q[0] && !dm_q[0]))
		else $error("single-ended zero not forced");

	chk_port_idle: assert property (
		@(posedge clk) disable iff (sys_rst)
		!ctl.port_en[0] |=> (dp_oe_n_q[0] && !pd_q[0] && !fs_pu_q[0]))
		else $error("disabled port shows a test condition");

	chk_pullups: assert property (
		@(posedge clk) disable iff (sys_rst)
		ctl.port_en[1] |=> (ls_pu_q[1] == $past(ctl.ls_pullup_en)
		&& fs_pu_q[1] == $past(ctl.fs_pullup_en)
		&& pd_q[1] == $past(ctl.pulldown_en)))
		else $error("pull resistor does not follow its control");
endmodule
`default_nettype wire

/* core/diag_xmem_regs.sv */
// Diagnostic and external page address register bank, with pin drivers.
// Assumes a simple internal register bus from the CPU and a write-only
// path from the external host port; both are synchronous to clk.
//
// Summary of operation
// - USB test register is CPU read/write, host-port write-only.
// - Bits 15..12 enable test conditions on ports 2B, 2A, 1B, 1A.
// - Bit 6 connects full-speed pull-downs on both data lines.
// - Bit 5 connects the low-speed pull-up on D-.
// - Bit 4 connects the full-speed pull-up on D+.
// - Force field: 1xx SE0, 01x toggling J/K, 001 J, 000 K.
// - Memory test register is write-only and resets to zero.
// - Arbitration value n makes n of every eight cycles dead.
// - Monitor bit echoes internal address bits 14..0 onto pins 14..0, and bit 15 onto pin 15 only once upper pins are freed.
// - Page map registers hold address bits 28..13 for their window.
// - Page window access puts page bits 21..13 on pins 8..0.
// - In SRAM mode pins 4..0 carry page bits 17..13 and pins 8..5 are driven to zero.
// - Page-mapped external access asserts the low-active chip select only while page bit 8 is clear.
// - Upper enable bit 3 frees pins 18..15 for general addressing.
// - From reset until enabled, pins 18..15 are driven high.
`timescale 1ns/1ps
`default_nettype none
module diag_xmem_regs
	import diag_pkg::*;
#(
	parameter int PORTS = 4
) (
	input  wire logic        clk,          // System clock, 250 MHz.
	input  wire logic        sys_rst,      // Synchronous reset, high.
	input  wire logic [15:0] cpu_addr,     // CPU register address.
	input  wire logic        cpu_wr,       // CPU register write strobe.
	input  wire logic        cpu_rd,       // CPU register read strobe.
	input  wire logic [15:0] cpu_wdata,    // CPU write data.
	output logic      [15:0] cpu_rdata_q,  // CPU read data.
	output logic             cpu_rvalid_q, // Read data valid pulse.
	input  wire logic [15:0] external_host_port_addr,  // Host port address.
	input  wire logic        external_host_port_wr,    // Host port write.
	input  wire logic [15:0] external_host_port_wdata, // Host port data.
	input  wire logic        mem_req,      // CPU memory access request.
	input  wire logic [15:0] mem_addr,     // Internal memory address.
	input  wire logic        sram_mode,    // External SRAM mode select.
	output logic             mem_gnt_q,    // Memory access granted.
	output logic      [18:0] ext_addr_q,   // External address pins.
	output logic             ext_page_chip_select_n_q, // Page select.
	output logic [PORTS-1:0] usb_dp_q,     // D+ drive value.
	output logic [PORTS-1:0] usb_dp_oe_n_q, // D+ enable, low drives.
	output logic [PORTS-1:0] usb_dm_q,     // D- drive value.
	output logic [PORTS-1:0] usb_dm_oe_n_q, // D- enable, low drives.
	output logic [PORTS-1:0] usb_pd_q,     // Test pull-downs.
	output logic [PORTS-1:0] usb_ls_pu_q,  // Test low-speed pull-up.
	output logic [PORTS-1:0] usb_fs_pu_q,  // Test full-speed pull-up.
	output logic [15:0] ext_timing_q       // Wait and width settings.
);
	diag_if ctl ();

	logic [15:0] page_one_q;
	logic [15:0] page_two_q;
	logic        upper_en_q;
	logic [15:0] usb_test_q;
	logic [15:0] mem_test_q;
	logic        wr_any;
	logic [15:0] wr_addr;
	logic [15:0] wr_data;
	logic        in_page_one;
	logic        in_page_two;
	logic [15:0] page_bits;
	logic        take;
	logic [14:0] low_pins_q;
	logic [3:0]  high_pins_q;

	// The CPU wins when both masters write in the same cycle.
	assign wr_any  = cpu_wr || external_host_port_wr;
	assign wr_addr = cpu_wr ? cpu_addr : external_host_port_addr;
	assign wr_data = cpu_wr ? cpu_wdata : external_host_port_wdata;

	function automatic logic hit(input logic [15:0] a,
		input logic [15:0] lo, input logic [15:0] hi);
		return (a >= lo) && (a <= hi);
	endfunction

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			page_one_q <= page_map_reset;
			page_two_q <= page_map_reset;
		end else if (wr_any) begin
			if (wr_addr == page_one_map_addr) begin
				page_one_q <= wr_data;
			end
			if (wr_addr == page_two_map_addr) begin
				page_two_q <= wr_data;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			upper_en_q   <= 1'b0;
			ext_timing_q <= ext_timing_reset;
		end else if (wr_any) begin
			if (wr_addr == upper_pin_enable_addr) begin
				upper_en_q <= wr_data[upper_en_bit];
			end
			if (wr_addr == ext_timing_addr) begin
				ext_timing_q <= wr_data & ext_timing_mask;
			end
		end
	end

	// Reserved positions are stored as zero whatever software writes.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			usb_test_q <= usb_line_test_reset;
			mem_test_q <= memory_test_reset;
		end else if (wr_any) begin
			if (wr_addr == usb_line_test_addr) begin
				usb_test_q <= wr_data & usb_line_test_mask;
			end
			if (wr_addr == memory_test_addr) begin
				mem_test_q <= wr_data & memory_test_mask;
			end
		end
	end

	assign ctl.port_en      = usb_test_q[port_en_lsb +: 4];
	assign ctl.pulldown_en  = usb_test_q[pulldown_bit];
	assign ctl.ls_pullup_en = usb_test_q[ls_pullup_bit];
	assign ctl.fs_pullup_en = usb_test_q[fs_pullup_bit];
	assign ctl.force_sel    = usb_test_q[force_lsb +: 3];
	assign ctl.arb_sel      = mem_test_q[arb_sel_lsb +: 3];

	// Only the CPU can read; the memory test register reads as zero.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cpu_rdata_q  <= 16'h0000;
			cpu_rvalid_q <= 1'b0;
		end else begin
			cpu_rvalid_q <= cpu_rd;
			case (cpu_addr)
				page_one_map_addr:     cpu_rdata_q <= page_one_q;
				page_two_map_addr:     cpu_rdata_q <= page_two_q;
				upper_pin_enable_addr: cpu_rdata_q <= 16'(upper_en_q)
					<< upper_en_bit;
				ext_timing_addr:       cpu_rdata_q <= ext_timing_q;
				usb_line_test_addr:    cpu_rdata_q <= usb_test_q;
				default:               cpu_rdata_q <= 16'h0000;
			endcase
		end
	end

	arb_throttle u_arb (
		.clk       (clk),
		.sys_rst   (sys_rst),
		.ctl       (ctl.arb),
		.mem_req   (mem_req),
		.mem_gnt_q (mem_gnt_q)
	);

	usb_line_force #(.PORTS(PORTS)) u_usb (
		.clk       (clk),
		.sys_rst   (sys_rst),
		.ctl       (ctl.usb),
		.dp_q      (usb_dp_q),
		.dp_oe_n_q (usb_dp_oe_n_q),
		.dm_q      (usb_dm_q),
		.dm_oe_n_q (usb_dm_oe_n_q),
		.pd_q      (usb_pd_q),
		.ls_pu_q   (usb_ls_pu_q),
		.fs_pu_q   (usb_fs_pu_q)
	);

	assign in_page_one = hit(mem_addr, page_one_win_lo, page_one_win_hi);
	assign in_page_two = hit(mem_addr, page_two_win_lo, page_two_win_hi);
	assign page_bits   = in_page_one ? page_one_q : page_two_q;
	assign take        = mem_req && ctl.slot_avail;

	// Pins 14..0 follow the access; a page window overlays pins 8..0.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			low_pins_q <= 15'h0000;
		end else if (mem_test_q[monitor_bit]) begin
			low_pins_q <= mem_addr[14:0];
		end else if (take) begin
			if (in_page_one || in_page_two) begin
				low_pins_q[14:9] <= mem_addr[14:9];
				if (sram_mode) begin
					low_pins_q[8:0] <= {4'h0, page_bits[4:0]};
				end else begin
					low_pins_q[8:0] <= page_bits[8:0];
				end
			end else begin
				low_pins_q <= mem_addr[14:0];
			end
		end
	end

	// Upper pins idle high until software frees them.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			high_pins_q <= upper_pins_idle;
		end else if (!upper_en_q) begin
			high_pins_q <= upper_pins_idle;
		end else if (mem_test_q[monitor_bit]) begin
			high_pins_q <= {3'h0, mem_addr[15]};
		end else if (take) begin
			if (in_page_one || in_page_two) begin
				high_pins_q <= page_bits[9:6];
			end else begin
				high_pins_q <= {3'h0, mem_addr[15]};
			end
		end
	end

	// Each pin group has its own register so that each has one writer.
	assign ext_addr_q = {high_pins_q, low_pins_q};

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ext_page_chip_select_n_q <= 1'b1;
		end else begin
			ext_page_chip_select_n_q <= !(take && !page_bits[8]
				&& (in_page_one || in_page_two));
		end
	end

	sequence page_access_s;
		mem_req && ctl.slot_avail && in_page_one && !mem_test_q[monitor_bit];
	endsequence

	sequence page_two_s;
		take && in_page_two && !sram_mode && !mem_test_q[monitor_bit];
	endsequence

	chk_page_pins: assert property (
		@(posedge clk) disable iff (sys_rst)
		(page_access_s and !sram_mode)
		|=> ext_addr_q[8:0] == $past(page_one_q[8:0]))
		else $error("page bits not on low address pins");

	chk_page_two_pins: assert property (
		@(posedge clk) disable iff (sys_rst)
		page_two_s |=> ext_addr_q[8:0] == $past(page_two_q[8:0]))
		else $error("page two bits not on low address pins");

	chk_sram_pins: assert property (
		@(posedge clk) disable iff (sys_rst)
		(page_access_s and sram_mode)
		|=> ext_addr_q[8:0] == {4'h0, $past(page_one_q[4:0])})
		else $error("SRAM mode drove more than five page pins");

	chk_page_select: assert property (
		@(posedge clk) disable iff (sys_rst)
		(page_access_s and !page_one_q[8])
		|=> !ext_page_chip_select_n_q ##1 1'b1)
		else $error("page chip select not asserted");

	chk_select_outside: assert property (
		@(posedge clk) disable iff (sys_rst)
		(take && !in_page_one && !in_page_two) |=> ext_page_chip_select_n_q)
		else $error("page chip select asserted outside the windows");

	chk_upper_idle: assert property (
		@(posedge clk) disable iff (sys_rst)
		!upper_en_q |=> ext_addr_q[18:15] == upper_pins_idle)
		else $error("upper pins not high while disabled");

	chk_monitor_echo: assert property (
		@(posedge clk) disable iff (sys_rst)
		mem_test_q[monitor_bit]
		|=> ext_addr_q[14:0] == $past(mem_addr[14:0]))
		else $error("monitor mode did not echo the address");

	chk_memtest_read: assert property (
		@(posedge clk) disable iff (sys_rst)
		(cpu_rd && cpu_addr == memory_test_addr)
		|=> (cpu_rvalid_q && cpu_rdata_q == 16'h0000))
		else $error("memory test register returned data");

	chk_read_valid: assert property (
		@(posedge clk) disable iff (sys_rst)
		1'b1 |=> cpu_rvalid_q == $past(cpu_rd))
		else $error("read valid does not follow the CPU read strobe");

	chk_host_write: assert property (
		@(posedge clk) disable iff (sys_rst)
		(external_host_port_wr && !cpu_wr
		&& external_host_port_addr == usb_line_test_addr)
		|=> usb_test_q == ($past(external_host_port_wdata)
		& usb_line_test_mask))
		else $error("host port write to USB test register lost");

	chk_page_write: assert property (
		@(posedge clk) disable iff (sys_rst)
		(cpu_wr && cpu_addr == page_two_map_addr) ##1 !wr_any
		##1 (cpu_rd && cpu_addr == page_two_map_addr)
		|=> cpu_rdata_q == $past(cpu_wdata, 3))
		else $error("page map register did not hold written value");

	chk_upper_enable: assert property (
		@(posedge clk) disable iff (sys_rst)
		(cpu_wr && cpu_addr == upper_pin_enable_addr)
		|=> upper_en_q == $past(cpu_wdata[upper_en_bit]))
		else $error("upper enable bit not stored");

	chk_grant_slot: assert property (
		@(posedge clk) disable iff (sys_rst)
		mem_gnt_q |-> $past(take))
		else $error("grant without a request in an available slot");

	chk_dead_hold: assert property (
		@(posedge clk) disable iff (sys_rst)
		(!ctl.slot_avail && !mem_test_q[monitor_bit])
		|=> $stable(ext_addr_q[14:0]))
		else $error("address pins moved in a dead slot");
endmodule
`default_nettype wire

/* test/usb_line_model.sv */
// Far-side model of the USB data lines of every port.
// Assumes active-low drive enables; pulls act only on undriven lines.
`timescale 1ns/1ps
`default_nettype none
module usb_line_model #(
	parameter int PORTS = 4
) (
	input  wire logic             clk,     // System clock.
	input  wire logic [PORTS-1:0] dp,      // D+ drive value.
	input  wire logic [PORTS-1:0] dp_oe_n, // D+ enable, low drives.
	input  wire logic [PORTS-1:0] dm,      // D- drive value.
	input  wire logic [PORTS-1:0] dm_oe_n, // D- enable, low drives.
	input  wire logic [PORTS-1:0] pd,      // Pull-downs on both lines.
	input  wire logic [PORTS-1:0] ls_pu,   // Pull-up on D-.
	input  wire logic [PORTS-1:0] fs_pu,   // Pull-up on D+.
	output logic      [PORTS-1:0] dp_line, // Resolved D+ level.
	output logic      [PORTS-1:0] dm_line  // Resolved D- level.
);
	logic [PORTS-1:0] dp_last = '0;
	logic [PORTS-1:0] dm_last = '0;

	// A floating line shows the inverse of its last level, so a stale
	// value can never pass for a driven one.
	always @(posedge clk) begin
		dp_last <= dp_line;
		dm_last <= dm_line;
	end

	always_comb begin
		for (int i = 0; i < PORTS; i++) begin
			dp_line[i] = !dp_oe_n[i] ? dp[i] :
				(fs_pu[i] ? 1'b1 : (pd[i] ? 1'b0 : ~dp_last[i]));
			dm_line[i] = !dm_oe_n[i] ? dm[i] :
				(ls_pu[i] ? 1'b1 : (pd[i] ? 1'b0 : ~dm_last[i]));
		end
	end
endmodule
`default_nettype wire

/* test/tb_top.sv */
// Self-checking bench for the diagnostic and page address register bank.
// Assumes the design package and the line model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import diag_pkg::*;
;
	logic        clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic [15:0] cpu_addr = 16'h0000;
	logic        cpu_wr = 1'b0;
	logic        cpu_rd = 1'b0;
	logic [15:0] cpu_wdata = 16'h0000;
	logic [15:0] cpu_rdata_q;
	logic        cpu_rvalid_q;
	logic [15:0] host_addr = 16'h0000;
	logic        host_wr = 1'b0;
	logic [15:0] host_wdata = 16'h0000;
	logic        mem_req = 1'b0;
	logic [15:0] mem_addr = 16'h0000;
	logic        sram_mode = 1'b0;
	logic        mem_gnt_q;
	logic [18:0] ext_addr_q;
	logic        ext_page_chip_select_n;
	logic [3:0]  dp, dp_oe_n, dm, dm_oe_n, pd, ls_pu, fs_pu;
	logic [3:0]  dp_line, dm_line;
	logic [15:0] timing;
	int          n_tests = 0;
	int          n_mismatch = 0;
	int          cycles = 0;
	int          p;
	int          g;
	logic [2:0]  sel;
	logic [1:0]  ln;
	logic [1:0]  ex;
	logic [3:0]  one;

	always #2 clk = ~clk;

	diag_xmem_regs #(.PORTS(4)) DUT (
		.clk(clk), .sys_rst(sys_rst),
		.cpu_addr(cpu_addr), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
		.cpu_wdata(cpu_wdata), .cpu_rdata_q(cpu_rdata_q),
		.cpu_rvalid_q(cpu_rvalid_q),
		.external_host_port_addr(host_addr),
		.external_host_port_wr(host_wr),
		.external_host_port_wdata(host_wdata),
		.mem_req(mem_req), .mem_addr(mem_addr), .sram_mode(sram_mode),
		.mem_gnt_q(mem_gnt_q), .ext_addr_q(ext_addr_q),
		.ext_page_chip_select_n_q(ext_page_chip_select_n),
		.usb_dp_q(dp), .usb_dp_oe_n_q(dp_oe_n), .usb_dm_q(dm),
		.usb_dm_oe_n_q(dm_oe_n), .usb_pd_q(pd), .usb_ls_pu_q(ls_pu),
		.usb_fs_pu_q(fs_pu), .ext_timing_q(timing)
	);

	usb_line_model #(.PORTS(4)) lines (
		.clk(clk), .dp(dp), .dp_oe_n(dp_oe_n), .dm(dm), .dm_oe_n(dm_oe_n),
		.pd(pd), .ls_pu(ls_pu), .fs_pu(fs_pu),
		.dp_line(dp_line), .dm_line(dm_line)
	);

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 4000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end

	task automatic check(input logic [18:0] seen, input logic [18:0] exp,
		input string msg);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t %s: %h not %h", $time, msg, seen,
				exp);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic cpu_write(input logic [15:0] a, input logic [15:0] d);
		@(negedge clk);
		cpu_addr = a;
		cpu_wdata = d;
		cpu_wr = 1'b1;
		@(negedge clk);
		cpu_wr = 1'b0;
	endtask

	task automatic host_write(input logic [15:0] a, input logic [15:0] d);
		@(negedge clk);
		host_addr = a;
		host_wdata = d;
		host_wr = 1'b1;
		@(negedge clk);
		host_wr = 1'b0;
	endtask

	task automatic rd_check(input logic [15:0] a, input logic [15:0] e,
		input string msg);
		int k;
		@(negedge clk);
		cpu_addr = a;
		cpu_rd = 1'b1;
		@(negedge clk);
		cpu_rd = 1'b0;
		k = 0;
		while (cpu_rvalid_q !== 1'b1 && k < 4) begin
			@(negedge clk);
			k++;
		end
		check(cpu_rvalid_q, 1'b1, "read valid");
		check(cpu_rdata_q, e, msg);
	endtask

	// Holds the request until granted; pins are settled on return.
	task automatic mem_go(input logic [15:0] a, input logic sm);
		int k;
		@(negedge clk);
		mem_addr = a;
		sram_mode = sm;
		mem_req = 1'b1;
		k = 0;
		do begin
			@(negedge clk);
			k++;
		end while (mem_gnt_q !== 1'b1 && k < 16);
		mem_req = 1'b0;
		check(mem_gnt_q, 1'b1, "grant");
	endtask

	initial begin
		repeat (3) @(negedge clk);
		sys_rst = 1'b0;
		@(negedge clk);
		check(ext_addr_q, 19'h78000, "pins after reset");
		check(ext_page_chip_select_n, 1'b1, "select idle");
		check({dp_oe_n, dm_oe_n}, 8'hff, "lines released");
		rd_check(page_one_map_addr, page_map_reset, "page one");
		rd_check(page_two_map_addr, page_map_reset, "page two");
		rd_check(upper_pin_enable_addr, 16'h0000, "upper en");
		rd_check(usb_line_test_addr, usb_line_test_reset, "usb");
		rd_check(ext_timing_addr, ext_timing_reset, "timing");
		$display("test reset done");

		cpu_write(usb_line_test_addr, 16'hf077);
		rd_check(usb_line_test_addr, 16'hf077, "usb all set");
		host_write(usb_line_test_addr, 16'h2005);
		rd_check(usb_line_test_addr, 16'h2005, "host write");
		for (int s = 0; s < 8; s++) begin
			sel = 3'(s);
			p = s % 4;
			one = 4'h1 << p;
			cpu_write(usb_line_test_addr, (16'h1000 << p) | {13'h0, sel});
			idle(2);
			check(dp_oe_n ^ one, 4'hf, "dp port enable");
			check(dm_oe_n ^ one, 4'hf, "dm port enable");
			ln = {dp_line[p], dm_line[p]};
			@(negedge clk);
			if (sel[1] && !sel[2]) begin
				check(ln[1] ^ ln[0], 1'b1, "jk differential");
				check({dp_line[p], dm_line[p]} ^ ln, 2'b11, "jk");
			end else begin
				ex = sel[2] ? 2'b00 : (sel[0] ? 2'b10 : 2'b01);
				check(ln, ex, "line state");
				check({dp_line[p], dm_line[p]}, ex, "line holds");
			end
		end
		cpu_write(usb_line_test_addr, 16'h5040);
		idle(2);
		check(pd, 4'h5, "pull-downs");
		check({ls_pu, fs_pu}, 8'h00, "pull-ups off");
		cpu_write(usb_line_test_addr, 16'ha030);
		idle(2);
		check(pd, 4'h0, "pull-downs off");
		check(ls_pu, 4'ha, "ls pull-up");
		check(fs_pu, 4'ha, "fs pull-up");
		cpu_write(usb_line_test_addr, 16'h0000);
		$display("test usb diagnostics done");

		for (int n = 0; n < 8; n++) begin
			cpu_write(memory_test_addr, {5'h00, 3'(n), 8'h00});
			@(negedge clk);
			mem_addr = 16'h1000;
			mem_req = 1'b1;
			g = 0;
			repeat (16) begin
				@(negedge clk);
				g += int'(mem_gnt_q === 1'b1);
			end
			mem_req = 1'b0;
			check(19'(g), 19'(16 - 2 * n), "grants");
		end
		rd_check(memory_test_addr, 16'h0000, "no readback");
		cpu_write(memory_test_addr, 16'h0000);
		$display("test arbitration done");

		cpu_write(page_one_map_addr, 16'h0012);
		host_write(page_two_map_addr, 16'h00ab);
		rd_check(page_two_map_addr, 16'h00ab, "host page");
		mem_go(16'h8000, 1'b0);
		check(ext_addr_q[8:0], 9'h012, "page one pins");
		check(ext_page_chip_select_n, 1'b0, "page select");
		check(ext_addr_q[18:15], upper_pins_idle, "upper held");
		mem_go(16'hbffe, 1'b0);
		check(ext_addr_q[8:0], 9'h0ab, "page two pins");
		cpu_write(page_one_map_addr, 16'h00f5);
		mem_go(16'h9000, 1'b1);
		check(ext_addr_q[8:0], 9'h015, "sram pins");
		cpu_write(page_two_map_addr, 16'h0100);
		rd_check(page_two_map_addr, 16'h0100, "cpu page");
		mem_go(16'ha000, 1'b0);
		check(ext_page_chip_select_n, 1'b1, "internal page");
		mem_go(16'h1000, 1'b0);
		check(ext_page_chip_select_n, 1'b1, "outside window");
		cpu_write(upper_pin_enable_addr, 16'h0008);
		rd_check(upper_pin_enable_addr, 16'h0008, "upper en");
		cpu_write(page_one_map_addr, 16'h0252);
		mem_go(16'h8000, 1'b0);
		check(ext_addr_q[18:15], 4'h9, "upper pins used");
		check(ext_addr_q[8:0], 9'h052, "page pins");
		cpu_write(ext_timing_addr, 16'h3a5c);
		rd_check(ext_timing_addr, 16'h3a5c, "timing rw");
		check(timing, 16'h3a5c, "timing out");
		$display("test page mapping done");

		cpu_write(memory_test_addr, 16'h0001);
		@(negedge clk);
		mem_addr = 16'h1234;
		idle(2);
		check(ext_addr_q[15:0], 16'h1234, "monitor echo");
		mem_addr = 16'h5678;
		idle(2);
		check(ext_addr_q[15:0], 16'h5678, "monitor follows");
		cpu_write(memory_test_addr, 16'h0000);
		@(negedge clk);
		mem_addr = 16'h0abc;
		idle(2);
		check(ext_addr_q[15:0] == 16'h0abc, 1'b0, "monitor off");
		$display("test monitor done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
